/* hdl/output_phase_adjust.sv */
// Output phase adjust and source select control for the output dividers
//
// Functional notes
// - Each trigger bit's rising edge starts coarse adjustment of its output unless a step is pending there or sync is set.
// - Trigger bit must return to zero first; a held one never retriggers.
// - Exactly the programmed five-bit count of whole periods is inserted.
// - Step period is that of the PLL for outputs 0-3 and of the currently selected source for outputs 4-7.
// - Fractional outputs add four-bit sixteenths of a period to their phase.
// - New fine value takes effect only when the sync bit toggles.
// - Toggling sync clears all coarse delay; program fine first.
// - Reserved bits are written zero; their read value is meaningless.
`timescale 1ns/1ps
module output_phase_adjust
  import phase_adjust_pkg::*;
(
  input  wire logic                               mclk_i,
  input  wire logic                               reset_i,
  input  wire logic [15:0]                        reg_addr_i,
  input  wire logic                               reg_wr_i,
  input  wire logic [7:0]                         reg_wdata_i,
  input  wire logic                               reg_rd_i,
  output logic      [7:0]                         reg_rdata_o,
  output logic                                    reg_rvalid_o,
  input  wire logic [NUM_SOURCES-1:0]             src_tick_i,
  output logic      [NUM_OUTPUTS-1:0]             period_swallow_o,
  output logic      [NUM_OUTPUTS-1:0]             phase_adjust_pending_o,
  output logic      [NUM_FINE-1:0][FINE_W-1:0]    fine_sixteenth_step_o,
  output logic                                    divider_sync_hold_o,
  output logic      [NUM_SEL-1:0][SEL_W-1:0]      output_source_select_o
);

  typedef struct packed {
    logic [7:0]                          trig;
    logic [NUM_OUTPUTS-1:0][COARSE_W-1:0] coarse;
    logic [NUM_FINE-1:0][FINE_W-1:0]     fine;
    logic [NUM_FINE-1:0][FINE_W-1:0]     fine_applied;
    logic                                sync;
    logic [NUM_SEL-1:0][SEL_W-1:0]       sel;
    logic [NUM_OUTPUTS-1:0]              start;
    logic                                clear;
    logic [7:0]                          rdata;
    logic                                rvalid;
  } ctrl_state_t;

  ctrl_state_t            st_r;
  ctrl_state_t            st_nxt;
  logic [NUM_OUTPUTS-1:0] tick;
  logic [NUM_OUTPUTS-1:0] pending;
  logic [NUM_OUTPUTS-1:0] swallow;

  phase_step_if step_bus [NUM_OUTPUTS] ();

  // ****************************************
  // Source tick routing
  // ****************************************
  function automatic logic pick_tick(input logic [SEL_W-1:0]       code,
                                     input logic [NUM_SOURCES-1:0] ticks);
    logic t;
    t = 1'b0;
    unique case (code)
      SRC_PLL:  t = ticks[TICK_PLL];
      SRC_Q2:   t = ticks[TICK_Q2];
      SRC_Q3:   t = ticks[TICK_Q3];
      SRC_REF0: t = ticks[TICK_REF0];
      SRC_REF1: t = ticks[TICK_REF1];
      // Reserved codes route no clock, so a step there stalls
      default:  t = 1'b0;
    endcase
    return t;
  endfunction

  always_comb begin
    tick[0] = src_tick_i[TICK_PLL];
    tick[1] = src_tick_i[TICK_PLL];
    tick[2] = src_tick_i[TICK_PLL];
    tick[3] = src_tick_i[TICK_PLL];
    for (int i = 0; i < NUM_SEL; i++) begin
      tick[FIRST_SEL_OUT+i] = pick_tick(st_r.sel[i], src_tick_i);
    end
  end

  // ****************************************
  // Register writes and reads
  // ****************************************
  always_comb begin
    st_nxt        = st_r;
    st_nxt.start  = '0;
    st_nxt.rvalid = 1'b0;
    if (reg_wr_i) begin
      if (reg_addr_i == ADDR_COARSE_TRIGGER) begin
        // Only a zero-to-one step of a bit launches its output
        st_nxt.trig  = reg_wdata_i;
        st_nxt.start = reg_wdata_i & ~st_r.trig;
      end
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        if (reg_addr_i == ADDR_COARSE_BASE + 16'(i)) begin
          st_nxt.coarse[i] = reg_wdata_i[COARSE_W-1:0];
        end
      end
      for (int i = 0; i < NUM_FINE; i++) begin
        if (reg_addr_i == ADDR_FINE_BASE + 16'(i)) begin
          st_nxt.fine[i] = reg_wdata_i[FINE_W-1:0];
        end
      end
      if (reg_addr_i == ADDR_DIV_SYNC) begin
        st_nxt.sync = reg_wdata_i[SYNC_BIT];
      end
      if (reg_addr_i == ADDR_SEL_FOUR_FIVE) begin
        st_nxt.sel[0] = reg_wdata_i[SEL_LO_POS +: SEL_W];
        st_nxt.sel[1] = reg_wdata_i[SEL_HI_POS +: SEL_W];
      end
      if (reg_addr_i == ADDR_SEL_SIX_SEVEN) begin
        st_nxt.sel[2] = reg_wdata_i[SEL_LO_POS +: SEL_W];
        st_nxt.sel[3] = reg_wdata_i[SEL_HI_POS +: SEL_W];
      end
    end
    // A toggle either way resyncs; fine steps land only here
    if (st_nxt.sync != st_r.sync) begin
      st_nxt.fine_applied = st_r.fine;
    end
    // Units stay cleared while dividers are held and on each toggle
    st_nxt.clear = st_nxt.sync | (st_nxt.sync != st_r.sync);
    if (reg_rd_i) begin
      st_nxt.rvalid = 1'b1;
      // Reserved bits and unmapped addresses read as zero
      st_nxt.rdata  = 8'h00;
      if (reg_addr_i == ADDR_COARSE_TRIGGER) begin
        st_nxt.rdata = st_r.trig;
      end
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        if (reg_addr_i == ADDR_COARSE_BASE + 16'(i)) begin
          st_nxt.rdata = {3'h0, st_r.coarse[i]};
        end
      end
      for (int i = 0; i < NUM_FINE; i++) begin
        if (reg_addr_i == ADDR_FINE_BASE + 16'(i)) begin
          st_nxt.rdata = {4'h0, st_r.fine[i]};
        end
      end
      if (reg_addr_i == ADDR_DIV_SYNC) begin
        st_nxt.rdata[SYNC_BIT] = st_r.sync;
      end
      if (reg_addr_i == ADDR_SEL_FOUR_FIVE) begin
        st_nxt.rdata = {1'b0, st_r.sel[1], 1'b0, st_r.sel[0]};
      end
      if (reg_addr_i == ADDR_SEL_SIX_SEVEN) begin
        st_nxt.rdata = {1'b0, st_r.sel[3], 1'b0, st_r.sel[2]};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_r.trig         <= TRIGGER_RST;
      st_r.coarse       <= {NUM_OUTPUTS{COARSE_RST}};
      st_r.fine         <= {NUM_FINE{FINE_RST}};
      st_r.fine_applied <= {NUM_FINE{FINE_RST}};
      st_r.sync         <= SYNC_RST;
      st_r.sel          <= {NUM_SEL{SEL_RST}};
      st_r.start        <= '0;
      st_r.clear        <= SYNC_RST;
      st_r.rdata        <= 8'h00;
      st_r.rvalid       <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Coarse step units
  // ****************************************
  for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_unit
    assign step_bus[g].start = st_r.start[g];
    assign step_bus[g].clear = st_r.clear;
    assign step_bus[g].tick  = tick[g];
    assign step_bus[g].count = st_r.coarse[g];
    assign pending[g]        = step_bus[g].pending;
    assign swallow[g]        = step_bus[g].swallow;

    phase_step_unit u_step (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .step    (step_bus[g])
    );
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata_o            = st_r.rdata;
  assign reg_rvalid_o           = st_r.rvalid;
  assign period_swallow_o       = swallow;
  assign phase_adjust_pending_o = pending;
  assign fine_sixteenth_step_o  = st_r.fine_applied;
  // One bit feeds every divider so release is simultaneous
  assign divider_sync_hold_o    = st_r.sync;
  assign output_source_select_o = st_r.sel;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_trigger_rise_start: assert property (
    reg_wr_i && reg_addr_i == ADDR_COARSE_TRIGGER && reg_wdata_i[0]
    && !st_r.trig[0] |=> st_r.start[0] ##1 !st_r.start[0])
    else $error("trigger rise did not start a coarse step");

  a_held_no_retrigger: assert property (
    st_r.start[1] |-> st_r.trig[1] && !$past(st_r.trig[1]))
    else $error("coarse step started without a zero-to-one edge");

  a_fine_waits_sync: assert property (
    $stable(st_r.sync) |-> $stable(st_r.fine_applied))
    else $error("fine step changed without a sync toggle");

  a_fine_on_toggle: assert property (
    $changed(st_r.sync) |-> st_r.fine_applied == $past(st_r.fine))
    else $error("sync toggle did not apply the fine value");

  // A trigger right after release may legally restart a step, so only the
  // cycle after the toggle is checked here; holding is checked below
  a_sync_clears_coarse: assert property (
    $changed(st_r.sync) |=> pending == '0)
    else $error("coarse delay survived a sync toggle");

  a_held_no_pending: assert property (
    st_r.sync && $past(st_r.sync) |-> pending == '0)
    else $error("coarse step ran while dividers were held");

  a_hold_tracks_sync: assert property (
    reg_wr_i && reg_addr_i == ADDR_DIV_SYNC
    |=> divider_sync_hold_o == $past(reg_wdata_i[SYNC_BIT]))
    else $error("divider hold did not follow the sync bit");

  a_reserved_read_zero: assert property (
    reg_rd_i && reg_addr_i == ADDR_SRC_SPARE |=> reg_rvalid_o
    && reg_rdata_o == 8'h00)
    else $error("reserved register read nonzero");

  a_reserved_sel_stall: assert property (
    st_r.sel[0] == 3'h1 |-> !tick[FIRST_SEL_OUT])
    else $error("reserved source code passed a tick");

  c_coarse_trigger: cover property (st_r.start[0] ##[1:50] swallow[0]);
  c_sync_toggle:    cover property ($fell(st_r.sync));
  c_ref_source:     cover property (st_r.sel[3] == SRC_REF1 && swallow[7]);

endmodule

/* hdl/phase_adjust_pkg.sv */
// Package: register map, field layouts, reset values, source codes
package phase_adjust_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] ADDR_COARSE_TRIGGER = 16'h009D;
  localparam logic [15:0] ADDR_COARSE_BASE    = 16'h009E;
  localparam logic [15:0] ADDR_FINE_BASE      = 16'h00A6;
  localparam logic [15:0] ADDR_DIV_SYNC       = 16'h00A8;
  localparam logic [15:0] ADDR_SEL_FOUR_FIVE  = 16'h00A9;
  localparam logic [15:0] ADDR_SEL_SIX_SEVEN  = 16'h00AA;
  localparam logic [15:0] ADDR_SRC_SPARE      = 16'h00AB;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int NUM_OUTPUTS     = 8;
  localparam int NUM_FINE        = 2;
  localparam int NUM_SEL         = 4;
  localparam int FIRST_SEL_OUT   = 4;
  localparam int FIRST_FINE_OUT  = 2;
  localparam int NUM_SOURCES     = 5;
  localparam int COARSE_W        = 5;
  localparam int FINE_W          = 4;
  localparam int SEL_W           = 3;
  localparam int SYNC_BIT        = 4;
  localparam int SEL_LO_POS      = 0;
  localparam int SEL_HI_POS      = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]          TRIGGER_RST = 8'h00;
  localparam logic [COARSE_W-1:0] COARSE_RST  = 5'h00;
  localparam logic [FINE_W-1:0]   FINE_RST    = 4'h0;
  localparam logic                SYNC_RST    = 1'b1;
  localparam logic [SEL_W-1:0]    SEL_RST     = 3'h0;

  // ****************************************
  // Output source codes and source tick index
  // ****************************************
  typedef enum logic [SEL_W-1:0] {
    SRC_PLL  = 3'h0,
    SRC_Q2   = 3'h2,
    SRC_Q3   = 3'h3,
    SRC_REF0 = 3'h4,
    SRC_REF1 = 3'h5
  } source_code_t;

  localparam int TICK_PLL  = 0;
  localparam int TICK_Q2   = 1;
  localparam int TICK_Q3   = 2;
  localparam int TICK_REF0 = 3;
  localparam int TICK_REF1 = 4;

endpackage

/* hdl/phase_step_if.sv */
// Interface: control and status of one coarse phase step unit
`timescale 1ns/1ps
interface phase_step_if;
  import phase_adjust_pkg::*;
  logic                start;
  logic                clear;
  logic                tick;
  logic [COARSE_W-1:0] count;
  logic                pending;
  logic                swallow;

  modport ctrl (output start, output clear, output tick, output count,
                input pending, input swallow);
  modport unit (input start, input clear, input tick, input count,
                output pending, output swallow);
endinterface

/* hdl/phase_step_unit.sv */
// Coarse phase step unit: swallows whole source periods of one output
`timescale 1ns/1ps
module phase_step_unit
  import phase_adjust_pkg::*;
(
  input  wire logic   mclk_i,
  input  wire logic   reset_i,
  phase_step_if.unit  step
);

  typedef struct packed {
    logic                pending;
    logic [COARSE_W-1:0] remain;
    logic                swallow;
  } unit_state_t;

  unit_state_t st_r;
  unit_state_t st_nxt;

  // ****************************************
  // Period insertion
  // ****************************************
  always_comb begin
    st_nxt         = st_r;
    st_nxt.swallow = 1'b0;
    if (step.clear) begin
      // Divider resync discards any delay still owed
      st_nxt.pending = 1'b0;
      st_nxt.remain  = '0;
    end else if (step.start && !st_r.pending) begin
      st_nxt.pending = (step.count != '0);
      st_nxt.remain  = step.count;
    end else if (st_r.pending && step.tick) begin
      // One source period is hidden from the divider per tick
      st_nxt.swallow = 1'b1;
      st_nxt.remain  = st_r.remain - 5'h01;
      if (st_r.remain == 5'h01) begin
        st_nxt.pending = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign step.pending = st_r.pending;
  assign step.swallow = st_r.swallow;

  // ****************************************
  // Checks
  // ****************************************
  logic [COARSE_W-1:0] loaded_r;
  logic [COARSE_W-1:0] inserted_r;

  always_ff @(posedge mclk_i) begin
    if (reset_i || step.clear) begin
      loaded_r   <= '0;
      inserted_r <= '0;
    end else if (step.start && !st_r.pending) begin
      loaded_r   <= step.count;
      inserted_r <= '0;
    end else if (st_r.swallow) begin
      inserted_r <= inserted_r + 5'h01;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_exact_period_count: assert property (
    $fell(st_r.pending) && !$past(step.clear) && !step.clear
    |=> inserted_r == loaded_r)
    else $error("inserted periods differ from coarse count");

  a_swallow_needs_tick: assert property (
    st_r.swallow |-> $past(step.tick) && $past(st_r.pending))
    else $error("period swallowed without a source tick");

  a_clear_drops_delay: assert property (
    step.clear |=> !st_r.pending ##1 !st_r.swallow)
    else $error("delay survived a divider resync");

  c_full_adjust: cover property (
    $rose(st_r.pending) ##[1:200] $fell(st_r.pending));

endmodule

/* test/tb_top.sv */
// Testbench: register access, coarse steps, fine steps, sync and source select
`timescale 1ns/1ps
module tb_top;
  import phase_adjust_pkg::*;

  // ****************************************
  // Signals and design instance
  // ****************************************
  logic                            mclk_i;
  logic                            reset_i;
  logic [15:0]                     reg_addr_i;
  logic                            reg_wr_i;
  logic [7:0]                      reg_wdata_i;
  logic                            reg_rd_i;
  logic [7:0]                      reg_rdata_o;
  logic                            reg_rvalid_o;
  logic [NUM_SOURCES-1:0]          src_tick_i;
  logic [NUM_OUTPUTS-1:0]          period_swallow_o;
  logic [NUM_OUTPUTS-1:0]          phase_adjust_pending_o;
  logic [NUM_FINE-1:0][FINE_W-1:0] fine_sixteenth_step_o;
  logic                            divider_sync_hold_o;
  logic [NUM_SEL-1:0][SEL_W-1:0]   output_source_select_o;
  int                              fail_count;
  int                              samples_checked;
  logic [2:0]                      sel [4];
  logic [3:0]                      f2;
  logic [3:0]                      f3;
  int                              m;

  output_phase_adjust output_phase_adjust_i (
    .mclk_i                 (mclk_i),
    .reset_i                (reset_i),
    .reg_addr_i             (reg_addr_i),
    .reg_wr_i               (reg_wr_i),
    .reg_wdata_i            (reg_wdata_i),
    .reg_rd_i               (reg_rd_i),
    .reg_rdata_o            (reg_rdata_o),
    .reg_rvalid_o           (reg_rvalid_o),
    .src_tick_i             (src_tick_i),
    .period_swallow_o       (period_swallow_o),
    .phase_adjust_pending_o (phase_adjust_pending_o),
    .fine_sixteenth_step_o  (fine_sixteenth_step_o),
    .divider_sync_hold_o    (divider_sync_hold_o),
    .output_source_select_o (output_source_select_o)
  );

  always #5 mclk_i = ~mclk_i;

  // ****************************************
  // Shared tasks and functions
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_wr_i    = 1'b0;
    // Let an edge pass so a following call never re-raises in this step
    @(posedge mclk_i);
    #1;
  endtask

  // Read answer is checked in the cycle right after the taking edge
  task automatic rchk(input logic [15:0] a, input logic [7:0] mask,
                      input logic [7:0] exp);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_rd_i   = 1'b0;
    chk("rvalid", reg_rvalid_o, 1'b1);
    chk("rdata", reg_rdata_o & mask, exp);
    @(posedge mclk_i);
    #1;
  endtask

  function automatic int tick_idx(input logic [2:0] c);
    case (c)
      3'h2:    return TICK_Q2;
      3'h3:    return TICK_Q3;
      3'h4:    return TICK_REF0;
      3'h5:    return TICK_REF1;
      default: return TICK_PLL;
    endcase
  endfunction

  task automatic idle(input int n, input logic [4:0] t);
    src_tick_i = t;
    repeat (n) begin
      @(posedge mclk_i);
      #1;
    end
  endtask

  // Foreign ticks first, so a step on the wrong source shows at once
  task automatic run_coarse(input int o, input logic [4:0] n);
    int i;
    int got;
    int idx;
    logic other;
    idx   = (o < 4) ? TICK_PLL : tick_idx(sel[o-4]);
    got   = 0;
    other = 1'b0;
    wr(16'(ADDR_COARSE_BASE + o), {3'h0, n});
    wr(ADDR_COARSE_TRIGGER, 8'(8'h01 << o));
    for (i = 0; i < 400; i++) begin
      src_tick_i = (i < 6) ? ~(5'(5'h01 << idx)) : 5'($urandom);
      @(posedge mclk_i);
      #1;
      if (period_swallow_o[o] === 1'b1) got++;
      other |= |(period_swallow_o & ~(8'(8'h01 << o)));
      if (i == 5) chk("pending_up", phase_adjust_pending_o[o], 1'b1);
      if (i == 5) chk("wrong_src", got, 0);
      if (i > 5 && phase_adjust_pending_o[o] !== 1'b1) break;
    end
    for (i = 0; i < 4; i++) begin
      src_tick_i = 5'h1F;
      @(posedge mclk_i);
      #1;
      if (period_swallow_o[o] === 1'b1) got++;
    end
    chk("swallow_count", got, n);
    chk("other_swallow", other, 1'b0);
    chk("pending_down", phase_adjust_pending_o[o], 1'b0);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    mclk_i          = 1'b0;
    reset_i         = 1'b1;
    reg_addr_i      = 16'h0000;
    reg_wr_i        = 1'b0;
    reg_wdata_i     = 8'h00;
    reg_rd_i        = 1'b0;
    src_tick_i      = 5'h00;
    fail_count      = 0;
    samples_checked = 0;
    void'($urandom(32'hE4DA6BAC));
    repeat (10) @(posedge mclk_i);
    #1;
    reset_i = 1'b0;
    chk("hold_rst", divider_sync_hold_o, 1'b1);
    chk("sel_rst", output_source_select_o, 12'h000);
    rchk(ADDR_COARSE_TRIGGER, 8'hFF, 8'h00);
    rchk(ADDR_COARSE_BASE, 8'h1F, 8'h00);
    rchk(16'h00A5, 8'h1F, 8'h00);
    rchk(ADDR_FINE_BASE, 8'h0F, 8'h00);
    rchk(ADDR_DIV_SYNC, 8'h1F, 8'h10);
    rchk(ADDR_SEL_SIX_SEVEN, 8'h77, 8'h00);
    rchk(16'h0050, 8'hFF, 8'h00);
    rchk(ADDR_SRC_SPARE, 8'hFF, 8'h00);
    wr(ADDR_DIV_SYNC, 8'h00);
    chk("hold_release", divider_sync_hold_o, 1'b0);
    $display("test reset_defaults done");

    for (m = 0; m < 4; m++) begin
      case ($urandom_range(4, 0))
        0: sel[m] = 3'h0;
        1: sel[m] = 3'h2;
        2: sel[m] = 3'h3;
        3: sel[m] = 3'h4;
        default: sel[m] = 3'h5;
      endcase
    end
    sel[0] = 3'h5;
    wr(ADDR_SEL_FOUR_FIVE, {1'b0, sel[1], 1'b0, sel[0]});
    wr(ADDR_SEL_SIX_SEVEN, {1'b0, sel[3], 1'b0, sel[2]});
    chk("sel_out", output_source_select_o,
        {sel[3], sel[2], sel[1], sel[0]});
    rchk(ADDR_SEL_FOUR_FIVE, 8'h77, {1'b0, sel[1], 1'b0, sel[0]});
    $display("test source_select done");

    // Count zero inserts nothing
    wr(ADDR_COARSE_BASE, 8'h00);
    wr(ADDR_COARSE_TRIGGER, 8'h01);
    idle(4, 5'h1F);
    chk("zero_count", phase_adjust_pending_o, 8'h00);
    chk("zero_swallow", period_swallow_o, 8'h00);
    // Bit 0 must drop again, or the first coarse run would be a held one
    wr(ADDR_COARSE_TRIGGER, 8'h00);
    for (m = 0; m < NUM_OUTPUTS; m++) begin
      run_coarse(m, (m == 1) ? 5'h01 : (m == 7) ? 5'h1F :
                 5'($urandom_range(31, 1)));
    end
    $display("test coarse_steps done");

    // Held one must not retrigger; zero then one does
    wr(ADDR_COARSE_TRIGGER, 8'h80);
    idle(4, 5'h1F);
    chk("held_one", phase_adjust_pending_o[7], 1'b0);
    wr(ADDR_COARSE_TRIGGER, 8'h00);
    run_coarse(7, 5'h04);
    $display("test retrigger done");

    // Reserved source code routes no tick, so the step stalls pending
    wr(ADDR_SEL_FOUR_FIVE, {1'b0, sel[1], 4'h1});
    wr(16'(ADDR_COARSE_BASE + 4), 8'h03);
    wr(ADDR_COARSE_TRIGGER, 8'h10);
    idle(8, 5'h1F);
    chk("stall_pend", phase_adjust_pending_o[4], 1'b1);
    chk("stall_swallow", period_swallow_o, 8'h00);
    $display("test reserved_source done");

    // Fine values wait for the sync toggle, which also drops coarse work
    f2 = 4'($urandom);
    f3 = 4'hF;
    wr(16'(ADDR_COARSE_BASE), 8'h1F);
    wr(ADDR_FINE_BASE, {4'h0, f2});
    wr(16'(ADDR_FINE_BASE + 1), {4'h0, f3});
    wr(ADDR_COARSE_TRIGGER, 8'h01);
    idle(4, 5'h00);
    chk("pend_before", phase_adjust_pending_o[0], 1'b1);
    chk("fine_early", fine_sixteenth_step_o, 8'h00);
    wr(ADDR_DIV_SYNC, 8'h10);
    chk("hold_set", divider_sync_hold_o, 1'b1);
    chk("fine_apply", fine_sixteenth_step_o, {f3, f2});
    idle(4, 5'h1F);
    chk("pend_clear", phase_adjust_pending_o, 8'h00);
    chk("no_swallow", period_swallow_o, 8'h00);
    wr(ADDR_DIV_SYNC, 8'h00);
    chk("hold_off", divider_sync_hold_o, 1'b0);
    chk("fine_keep", fine_sixteenth_step_o, {f3, f2});
    $display("test sync_fine done");
    wrap_up();
  end
endmodule
